// *** src/spcb_serial_port.v ***
// Notes on behaviour
// - baud register selects generator clock source and sets bit rate for all modes.
// - baud write loads control value; read returns live down-counter value.
// - control bit 6 enables divide-by-two prescaler on the baud clock.
// - control bit 5 picks parity polarity: 0 even, 1 odd.
// - control bit 4 is ninth tx bit in mode 2 and in mode 3 without parity; cleared after each transmission.
// - receive enable arms RXD; falling edge starts reception in modes 1-3.
// - clearing receive enable aborts reception at once and blocks new ones.
// - control bit 2 enables parity in modes 1 and 3; ignored in mode 2.
// - with parity enabled status bit 7 shows receive parity error.
// - writing a different mode empties the transmit buffer and aborts transfers.
//
// The APB interface to the registers was left to the implementer.
`include "spcb_map.vh"

module spcb_serial_port (
	input  wire        pclk,     // bus clock
	input  wire        presetn,  // async reset, active low
	input  wire        psel,     // apb select
	input  wire        penable,  // apb access phase
	input  wire        pwrite,   // apb direction
	input  wire [15:0] paddr,    // apb byte address
	input  wire [31:0] pwdata,   // apb write data
	output wire [31:0] prdata,   // apb read data
	output wire        pready,   // apb ready
	output wire        pslverr,  // apb error on unmapped address
	input  wire        t1clk,    // external baud clock source
	input  wire        rxd_i,    // receive pin level
	output wire        rxd_o,    // receive pin drive value (mode 0 tx)
	output wire        rxd_oe,   // receive pin drive enable
	output wire        txd       // transmit line or mode 0 shift clock
);

	localparam TX_IDLE  = 1'b0;
	localparam TX_SHIFT = 1'b1;
	localparam RX_IDLE  = 1'b0;
	localparam RX_SHIFT = 1'b1;

	reg [31:0] prdata_r;
	reg        pready_r;
	reg        pslverr_r;
	reg [7:0]  ctrl_r;
	reg [15:0] baud_r;
	reg [14:0] bcnt_r;
	reg        t1_prev_r;
	reg        presc_r;
	reg        ti_r;
	reg        ri_r;
	reg        rb8_r;
	reg [7:0]  rxbuf_r;
	reg [7:0]  fifo_r [0:1];
	reg        fwp_r;
	reg        frp_r;
	reg [1:0]  fcnt_r;
	reg        tx_st_r;
	reg [10:0] tx_sh_r;
	reg [2:0]  tx_cnt_r;
	reg [3:0]  tx_left_r;
	reg        rx_st_r;
	reg [10:0] rx_sh_r;
	reg [2:0]  rx_cnt_r;
	reg [3:0]  rx_left_r;
	reg        rxd_prev_r;
	reg        txd_r;
	reg        rxd_o_r;
	reg        rxd_oe_r;

	reg [31:0] prdata_nxt;
	reg        map_hit;
	reg [10:0] tx_frame;
	reg [3:0]  tx_len;
	reg [3:0]  rx_len;
	reg [7:0]  rx_data;
	reg        rx_ninth;
	reg        rx_perr;
	reg        txd_nxt;

	function par_of;
		input [7:0] d;
		input       pol;
		input       m1;
		begin
			par_of = (m1 ? (^d[6:0]) : (^d)) ^ pol;
		end
	endfunction

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign txd     = txd_r;
	assign rxd_o   = rxd_o_r;
	assign rxd_oe  = rxd_oe_r;

	// bus decode
	wire       acc       = psel & penable;
	wire       done      = acc & pready_r;
	wire       sel_ctrl  = (paddr == `SPCB_ADDR_CTRL);
	wire       sel_baud  = (paddr == `SPCB_ADDR_BAUD);
	wire       sel_stat  = (paddr == `SPCB_ADDR_STATUS);
	wire       sel_txb   = (paddr == `SPCB_ADDR_TXBUF);
	wire       wr_ctrl   = done & pwrite & sel_ctrl;
	wire       wr_baud   = done & pwrite & sel_baud;
	wire       wr_stat   = done & pwrite & sel_stat;
	wire       wr_txb    = done & pwrite & sel_txb;
	wire       fifo_full = (fcnt_r == `SPCB_FIFO_DEPTH);
	// a buffer write waits in the access phase while both entries are taken
	wire       stall     = pwrite & sel_txb & fifo_full;

	wire [1:0] mode      = ctrl_r[`SPCB_CTRL_MODE_HI:`SPCB_CTRL_MODE_LO];
	wire       mode0     = (mode == `SPCB_MODE0);
	wire       mode1     = (mode == `SPCB_MODE1);
	wire       parity_enable       = ctrl_r[`SPCB_CTRL_PEN] & ~(mode == `SPCB_MODE2);
	wire       ren       = ctrl_r[`SPCB_CTRL_REN];
	wire       pol       = ctrl_r[`SPCB_CTRL_PAR];
	wire       mode_chg  = wr_ctrl & (pwdata[1:0] != mode);
	wire       tx_busy   = (tx_st_r == TX_SHIFT);
	wire       rx_busy   = (rx_st_r == RX_SHIFT);

	// baud generator
	wire       src_tick  = baud_r[`SPCB_BAUD_CLKSRC] ? (t1clk & ~t1_prev_r) : 1'b1;
	wire       raw_tick  = src_tick & (bcnt_r == 15'h0000);
	wire       tick      = raw_tick & (~ctrl_r[`SPCB_CTRL_PRS] | presc_r);

	wire [7:0] tx_data   = fifo_r[frp_r];
	wire       tx_par    = par_of(tx_data, pol, mode1);
	wire       tx_ninth  = parity_enable ? tx_par : ctrl_r[`SPCB_CTRL_TB8];
	wire       tx_start  = ~tx_busy & (fcnt_r != 2'h0) & ~mode_chg & (~mode0 | ~ren);
	wire       tx_step   = tx_busy & tick & (tx_cnt_r == `SPCB_TICK_LAST);
	wire       tx_end    = tx_step & (tx_left_r == 4'h1);

	wire       rx_fall   = rxd_prev_r & ~rxd_i;
	wire       rx_start  = ~rx_busy & ren & ~mode_chg & (mode0 ? (~ri_r & ~tx_busy) : rx_fall);
	wire       rx_step   = rx_busy & tick & (rx_cnt_r == `SPCB_TICK_LAST);
	wire [10:0] rx_in    = {rxd_i, rx_sh_r[10:1]};
	wire       rx_false  = rx_step & ~mode0 & (rx_left_r == rx_len) & rxd_i;
	wire       rx_end    = rx_step & (rx_left_r == 4'h1);
	wire       ri_set    = rx_end & ~((mode == `SPCB_MODE2) & ~rx_ninth);
	wire       ti_set    = tx_step & (mode0 ? (tx_left_r == 4'h1) : (tx_left_r == 4'h2));

	always @* begin
		case (mode)
			`SPCB_MODE0: begin
				tx_frame = {3'b111, tx_data};
				tx_len   = `SPCB_LEN_M0;
			end
			`SPCB_MODE1: begin
				tx_frame = {2'b11, (parity_enable ? tx_par : tx_data[7]), tx_data[6:0], 1'b0};
				tx_len   = `SPCB_LEN_M1;
			end
			default: begin
				tx_frame = {1'b1, tx_ninth, tx_data, 1'b0};
				tx_len   = `SPCB_LEN_M23;
			end
		endcase
	end

	always @* begin
		rx_data  = rx_in[8:1];
		rx_ninth = rx_in[9];
		rx_len   = `SPCB_LEN_M23;
		case (mode)
			`SPCB_MODE0: begin
				rx_data = rx_in[10:3];
				rx_len  = `SPCB_LEN_M0;
			end
			`SPCB_MODE1: begin
				rx_data  = rx_in[9:2];
				rx_ninth = rx_in[10];
				rx_len   = `SPCB_LEN_M1;
			end
			default: begin
				rx_data  = rx_in[8:1];
				rx_ninth = rx_in[9];
			end
		endcase
		rx_perr = mode1 ? (par_of(rx_data, pol, 1'b1) != rx_data[7]) :
			(par_of(rx_data, pol, 1'b0) != rx_ninth);
	end

	always @* begin
		map_hit    = 1'b1;
		prdata_nxt = 32'h0000_0000;
		case (paddr)
			`SPCB_ADDR_CTRL: prdata_nxt[7:0] = ctrl_r;
			`SPCB_ADDR_BAUD: prdata_nxt[15:0] = {baud_r[`SPCB_BAUD_CLKSRC], bcnt_r};
			`SPCB_ADDR_RXBUF: prdata_nxt[7:0] = rxbuf_r;
			`SPCB_ADDR_TXBUF: prdata_nxt[7:0] = 8'h00;
			`SPCB_ADDR_STATUS: begin
				prdata_nxt[`SPCB_STAT_TI]     = ti_r;
				prdata_nxt[`SPCB_STAT_RI]     = ri_r;
				prdata_nxt[`SPCB_STAT_TXBUSY] = tx_busy;
				prdata_nxt[`SPCB_STAT_RXBUSY] = rx_busy;
				prdata_nxt[`SPCB_STAT_FULL]   = fifo_full;
				prdata_nxt[`SPCB_STAT_RB8]    = rb8_r;
			end
			default: map_hit = 1'b0;
		endcase
	end

	always @* begin
		txd_nxt = 1'b1;
		if (mode0) begin
			if (tx_busy) begin
				txd_nxt = tx_cnt_r[2];
			end else if (rx_busy) begin
				txd_nxt = rx_cnt_r[2];
			end
		end else if (tx_busy) begin
			txd_nxt = tx_sh_r[0];
		end
	end

	// apb slave: pready rises one cycle into the access phase unless stalled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			if (acc & ~pready_r & ~stall) begin
				pready_r  <= 1'b1;
				pslverr_r <= ~map_hit;
				prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
			end else begin
				pready_r  <= 1'b0;
				pslverr_r <= 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `SPCB_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata[7:0] & `SPCB_CTRL_WMASK;
		end else if (tx_end) begin
			ctrl_r[`SPCB_CTRL_TB8] <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_r    <= `SPCB_BAUD_RST;
			bcnt_r    <= 15'h0000;
			t1_prev_r <= 1'b0;
			presc_r   <= 1'b0;
		end else begin
			t1_prev_r <= t1clk;
			if (wr_baud) begin
				baud_r  <= pwdata[15:0];
				bcnt_r  <= pwdata[`SPCB_BAUD_VAL_HI:0];
				presc_r <= 1'b0;
			end else if (raw_tick) begin
				bcnt_r  <= baud_r[`SPCB_BAUD_VAL_HI:0];
				presc_r <= ~presc_r;
			end else if (src_tick) begin
				bcnt_r <= bcnt_r - 15'h0001;
			end
		end
	end

	// two-entry transmit buffer
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_fifo
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					fifo_r[gi] <= 8'h00;
				end else if (wr_txb & (fwp_r == gi)) begin
					fifo_r[gi] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwp_r  <= 1'b0;
			frp_r  <= 1'b0;
			fcnt_r <= 2'h0;
		end else if (mode_chg) begin
			fwp_r  <= 1'b0;
			frp_r  <= 1'b0;
			fcnt_r <= 2'h0;
		end else begin
			if (wr_txb) begin
				fwp_r <= ~fwp_r;
			end
			if (tx_start) begin
				frp_r <= ~frp_r;
			end
			case ({wr_txb, tx_start})
				2'b10: fcnt_r <= fcnt_r + 2'h1;
				2'b01: fcnt_r <= fcnt_r - 2'h1;
				default: fcnt_r <= fcnt_r;
			endcase
		end
	end

	// transmitter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r   <= TX_IDLE;
			tx_sh_r   <= 11'h7ff;
			tx_cnt_r  <= `SPCB_TICK_ZERO;
			tx_left_r <= 4'h0;
		end else if (mode_chg) begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 11'h7ff;
		end else begin
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_start) begin
						tx_st_r   <= TX_SHIFT;
						tx_sh_r   <= tx_frame;
						tx_cnt_r  <= `SPCB_TICK_ZERO;
						tx_left_r <= tx_len;
					end
				end
				TX_SHIFT: begin
					if (tick) begin
						tx_cnt_r <= tx_cnt_r + 3'h1;
					end
					if (tx_step) begin
						tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
						tx_left_r <= tx_left_r - 4'h1;
					end
					if (tx_end) begin
						tx_st_r <= TX_IDLE;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// receiver
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r    <= RX_IDLE;
			rx_sh_r    <= 11'h000;
			rx_cnt_r   <= `SPCB_TICK_ZERO;
			rx_left_r  <= 4'h0;
			rxd_prev_r <= 1'b1;
		end else begin
			rxd_prev_r <= rxd_i;
			if (mode_chg | ~ren) begin
				rx_st_r <= RX_IDLE;
			end else begin
				case (rx_st_r)
					RX_IDLE: begin
						if (rx_start) begin
							rx_st_r   <= RX_SHIFT;
							rx_cnt_r  <= mode0 ? `SPCB_TICK_ZERO : `SPCB_TICK_HALF;
							rx_left_r <= rx_len;
						end
					end
					RX_SHIFT: begin
						if (tick) begin
							rx_cnt_r <= rx_cnt_r + 3'h1;
						end
						if (rx_step) begin
							rx_sh_r   <= rx_in;
							rx_left_r <= rx_left_r - 4'h1;
						end
						if (rx_false | rx_end) begin
							rx_st_r <= RX_IDLE;
						end
					end
					default: rx_st_r <= RX_IDLE;
				endcase
			end
		end
	end

	// status flags: a hardware set beats a software clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ti_r    <= 1'b0;
			ri_r    <= 1'b0;
			rb8_r   <= 1'b0;
			rxbuf_r <= 8'h00;
		end else begin
			if (ti_set) begin
				ti_r <= 1'b1;
			end else if (wr_stat & pwdata[`SPCB_STAT_TI]) begin
				ti_r <= 1'b0;
			end
			if (ri_set & ren & ~mode_chg) begin
				ri_r <= 1'b1;
			end else if (wr_stat & pwdata[`SPCB_STAT_RI]) begin
				ri_r <= 1'b0;
			end
			if (rx_end & ren & ~mode_chg) begin
				rxbuf_r <= rx_data;
				rb8_r   <= parity_enable ? rx_perr : rx_ninth;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_r    <= 1'b1;
			rxd_o_r  <= 1'b1;
			rxd_oe_r <= 1'b0;
		end else begin
			txd_r    <= txd_nxt;
			rxd_o_r  <= tx_sh_r[0];
			rxd_oe_r <= mode0 & tx_busy;
		end
	end

endmodule // spcb_serial_port

// *** src/spcb_map.vh ***
`ifndef SPCB_MAP_VH
`define SPCB_MAP_VH

// register indices; the byte address is four times the index
`define SPCB_IDX_RXBUF     14'h1fb8
`define SPCB_IDX_STATUS    14'h1fb9
`define SPCB_IDX_TXBUF     14'h1fba
`define SPCB_IDX_CTRL      14'h1fbb
`define SPCB_IDX_BAUD      14'h1fbc
`define SPCB_ADDR_RXBUF    {`SPCB_IDX_RXBUF, 2'b00}
`define SPCB_ADDR_STATUS   {`SPCB_IDX_STATUS, 2'b00}
`define SPCB_ADDR_TXBUF    {`SPCB_IDX_TXBUF, 2'b00}
`define SPCB_ADDR_CTRL     {`SPCB_IDX_CTRL, 2'b00}
`define SPCB_ADDR_BAUD     {`SPCB_IDX_BAUD, 2'b00}

// reset values and control write mask
`define SPCB_CTRL_RST      8'h00
`define SPCB_BAUD_RST      16'h0000
`define SPCB_CTRL_WMASK    8'h7f

// control fields
`define SPCB_CTRL_PRS      6
`define SPCB_CTRL_PAR      5
`define SPCB_CTRL_TB8      4
`define SPCB_CTRL_REN      3
`define SPCB_CTRL_PEN      2
`define SPCB_CTRL_MODE_HI  1
`define SPCB_CTRL_MODE_LO  0

// mode encodings
`define SPCB_MODE0         2'b00
`define SPCB_MODE1         2'b01
`define SPCB_MODE2         2'b10
`define SPCB_MODE3         2'b11

// status fields
`define SPCB_STAT_TI       0
`define SPCB_STAT_RI       1
`define SPCB_STAT_TXBUSY   2
`define SPCB_STAT_RXBUSY   3
`define SPCB_STAT_FULL     4
`define SPCB_STAT_RB8      7

// baud register fields
`define SPCB_BAUD_CLKSRC   15
`define SPCB_BAUD_VAL_HI   14

// bit timing in baud ticks, frame lengths in bits, transmit buffer depth
`define SPCB_TICK_LAST     3'h7
`define SPCB_TICK_HALF     3'h4
`define SPCB_TICK_ZERO     3'h0
`define SPCB_LEN_M0        4'h8
`define SPCB_LEN_M1        4'ha
`define SPCB_LEN_M23       4'hb
`define SPCB_FIFO_DEPTH    2'h2

`endif

// *** bench/spcb_assertions.sv ***
`include "spcb_map.vh"

module spcb_chk (
	input wire        pclk,     // clock
	input wire        presetn,  // reset
	input wire        psel,     // select
	input wire        penable,  // enable
	input wire        pwrite,   // write
	input wire [15:0] paddr,    // address
	input wire [31:0] pwdata,   // wdata
	input wire [31:0] prdata,   // rdata
	input wire        pready,   // ready
	input wire        rxd_oe,   // rx pin drive
	input wire        txd       // tx line
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire         done    = psel && penable && pready;
	wire         wr_ctrl = done && pwrite && paddr == `SPCB_ADDR_CTRL;
	wire         wr_baud = done && pwrite && paddr == `SPCB_ADDR_BAUD;
	wire         rd_ctrl = done && !pwrite && paddr == `SPCB_ADDR_CTRL;
	wire         rd_baud = done && !pwrite && paddr == `SPCB_ADDR_BAUD;
	wire         rd_stat = done && !pwrite && paddr == `SPCB_ADDR_STATUS;
	logic [7:0]  ctrl_r;
	logic [15:0] baud_r;
	// shadow of what software last wrote
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 8'h00;
			baud_r <= 16'h0000;
		end else begin
			if (wr_ctrl)
				ctrl_r <= pwdata[7:0];
			if (wr_baud)
				baud_r <= pwdata[15:0];
		end
	end
	property p_rsvd;
		rd_ctrl |-> prdata[31:7] == 25'h000_0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("ctrl reserved bits set");
	property p_mode;
		rd_ctrl |-> {prdata[3], prdata[1:0]} == {ctrl_r[3], ctrl_r[1:0]};
	endproperty
	a_mode: assert property (p_mode) else $error("ctrl mode readback");
	property p_cfg;
		rd_ctrl |-> prdata[6:5] == ctrl_r[6:5];
	endproperty
	a_cfg: assert property (p_cfg) else $error("ctrl config readback");
	property p_tb8;
		rd_ctrl && prdata[4] |-> ctrl_r[4];
	endproperty
	a_tb8: assert property (p_tb8) else $error("ninth bit set by itself");
	property p_baud;
		rd_baud |-> prdata[31:15] == {16'h0000, baud_r[15]} && prdata[14:0] <= baud_r[14:0];
	endproperty
	a_baud: assert property (p_baud) else $error("baud counter out of range");
	property p_oe;
		(ctrl_r[1:0] != 2'b00) [*2] |-> !rxd_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("rx pin driven in async mode");
	property p_abort;
		wr_ctrl && pwdata[1:0] != ctrl_r[1:0] |-> ##[1:3] (txd && !rxd_oe) [*4];
	endproperty
	a_abort: assert property (p_abort) else $error("mode change did not abort");
	property p_rxoff;
		rd_stat && !ctrl_r[3] |-> !prdata[`SPCB_STAT_RXBUSY];
	endproperty
	a_rxoff: assert property (p_rxoff) else $error("receiver busy while off");
endmodule // spcb_chk

// *** bench/spcb_remote.sv ***
module spcb_remote (
	input  wire logic clk,  // clock
	input  wire logic txd,  // line from port
	output logic      rxd   // line to port
);
	timeunit 1ns;
	timeprecision 1ps;
	int          bit_len = 16;
	int          nbits   = 10;
	int          frames  = 0;
	logic [10:0] got;
	initial rxd = 1'b1;
	// capture at mid-bit, start bit lands in bit 0
	always @(negedge txd) begin
		got = 11'h000;
		repeat (bit_len / 2) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			got[i] = txd;
			repeat (bit_len) @(posedge clk);
		end
		frames++;
	end
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (bit_len) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask
endmodule // spcb_remote

// *** bench/test_serial_port_control_baud.sv ***
`include "spcb_map.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end

module test_serial_port_control_baud;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [15:0] paddr   = 16'h0000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] q;
	logic        err;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         rxd_o;
	wire         rxd_oe;
	wire         txd;
	wire         rem_rxd;
	wire         rxd_line = rxd_oe ? rxd_o : rem_rxd;
	int          errors     = 0;
	int          num_checks = 0;

	always #5 pclk = ~pclk;

	spcb_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.t1clk(1'b0), .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd(txd));
	spcb_remote remote (.clk(pclk), .txd(txd), .rxd(rem_rxd));

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(q, e)
	endtask

	task automatic t_regs;
		rd(`SPCB_ADDR_CTRL, 32'h0000_0000);
		rd(`SPCB_ADDR_BAUD, 32'h0000_0000);
		apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_00ff);
		rd(`SPCB_ADDR_CTRL, 32'h0000_007f);
		apb(1'b0, 16'h0100, 32'h0000_0000);
		`CHK({err, q}, 33'h1_0000_0000)
		$display("regs done");
	endtask

	task automatic t_baud;
		logic [31:0] a;
		apb(1'b1, `SPCB_ADDR_BAUD, 32'h0000_0005);
		apb(1'b0, `SPCB_ADDR_BAUD, 32'h0000_0000);
		a = q;
		apb(1'b0, `SPCB_ADDR_BAUD, 32'h0000_0000);
		`CHK(a <= 32'h0000_0005 && q <= 32'h0000_0005 && a != q, 1'b1)
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK(q[3:2], 2'b00)
		apb(1'b1, `SPCB_ADDR_BAUD, 32'h0000_0001);
		$display("baud done");
	endtask

	task automatic t_tx(input logic [7:0] c, input logic [7:0] d, input logic [10:0] e, input int nb);
		int f0;
		int n;
		n = 0;
		remote.nbits = nb;
		f0 = remote.frames;
		apb(1'b1, `SPCB_ADDR_CTRL, {24'h00_0000, c});
		apb(1'b1, `SPCB_ADDR_TXBUF, {24'h00_0000, d});
		while (remote.frames == f0 && n < 800) begin
			@(posedge pclk);
			n++;
		end
		`CHK(remote.got, e)
		apb(1'b0, `SPCB_ADDR_CTRL, 32'h0000_0000);
		`CHK(q[4], 1'b0)
		$display("tx %h done", c);
	endtask

	task automatic t_rx;
		apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_000f);
		remote.send({2'b11, 8'h0f, 1'b0}, 11);
		repeat (20) @(posedge pclk);
		rd(`SPCB_ADDR_RXBUF, 32'h0000_000f);
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK({q[7], q[1]}, 2'b11)
		apb(1'b1, `SPCB_ADDR_STATUS, 32'h0000_0003);
		fork
			remote.send({2'b10, 8'h55, 1'b0}, 11);
			begin
				repeat (40) @(posedge pclk);
				apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_0007);
			end
		join
		repeat (20) @(posedge pclk);
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK({q[3], q[1]}, 2'b00)
		$display("rx done");
	endtask

	task automatic t_abort;
		apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_0001);
		apb(1'b1, `SPCB_ADDR_TXBUF, 32'h0000_0000);
		repeat (30) @(posedge pclk);
		apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		`CHK(txd, 1'b1)
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK(q[2], 1'b0)
		$display("abort done");
	endtask

	task automatic t_m0;
		apb(1'b1, `SPCB_ADDR_CTRL, 32'h0000_0000);
		apb(1'b1, `SPCB_ADDR_TXBUF, 32'h0000_005a);
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK(q[2], 1'b1)
		`CHK({rxd_oe, rxd_o}, 2'b10)
		repeat (200) @(posedge pclk);
		apb(1'b0, `SPCB_ADDR_STATUS, 32'h0000_0000);
		`CHK({q[2], q[0]}, 2'b01)
		$display("mode0 done");
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		final_report;
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_baud;
		t_tx(8'h25, 8'h35, {2'b01, ^7'h35 ^ 1'b1, 7'h35, 1'b0}, 10);
		t_tx(8'h13, 8'ha5, {2'b11, 8'ha5, 1'b0}, 11);
		t_tx(8'h17, 8'h0f, {1'b1, ^8'h0f, 8'h0f, 1'b0}, 11);
		t_tx(8'h16, 8'h0f, {2'b11, 8'h0f, 1'b0}, 11);
		remote.bit_len = 32;
		t_tx(8'h41, 8'h3c, {2'b01, 8'h3c, 1'b0}, 10);
		remote.bit_len = 16;
		t_rx;
		t_abort;
		t_m0;
		final_report;
	end
endmodule // test_serial_port_control_baud

bind spcb_serial_port spcb_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .rxd_oe(rxd_oe),
	.txd(txd));
